/* rtl/epa_regs.sv */
// Enable pin assignment register bank: pin A to converters and top linear regulators,
// pin B to linear regulators 1..8.
// Assumes a simple synchronous byte register port from the serial interface logic and
// a one-time-programmable default presented as stable straps.
//
// Overview of operation
// - Bit 5 of register 30h lets pin A drive step-down converter 4.
// - Bits 4..2 of 30h let pin A drive converters 3..1.
// - Bits 1..0 of 30h let pin A drive linear regulators 10 and 9.
// - Bits 7..6 of 30h are reserved, read zero, writes ignored.
// - Bits 7..0 of 31h let pin B drive linear regulators 8..1.
// - Power-on reset restores both registers to defaults, discarding writes.
`timescale 1ns/10ps
`include "epa_map.svh"
module epa_regs
  import epa_pkg::*;
#(
  parameter epa_byte_t OTP_A = `EPA_OTP_A_DEFAULT, // Default pin A assignment
  parameter epa_byte_t OTP_B = `EPA_OTP_B_DEFAULT  // Default pin B assignment
) (
  input  wire logic       REF_CLK,        // 40 MHz clock
  input  wire logic       RSTN,           // Power-on reset, sync, active low
  input  wire epa_addr_t  REG_ADDR,       // Register address
  input  wire logic       REG_WR,         // Write strobe
  input  wire epa_byte_t  REG_WDATA,      // Write data
  output epa_byte_t       REG_RDATA,      // Read data, registered
  input  wire logic       ENABLE_PIN_A,   // Pin A, asynchronous
  input  wire logic       ENABLE_PIN_B,   // Pin B, asynchronous
  output logic [3:0]      CONV_PIN_REQ,   // Pin request, converters 4..1
  output logic [1:0]      LIN_HI_PIN_REQ, // Pin request, linear regulators 10..9
  output logic [7:0]      LIN_LO_PIN_REQ  // Pin request, linear regulators 8..1
);
  epa_byte_t   pin_a_converter_assign_r, pin_a_converter_assign_nxt;
  epa_byte_t   pin_b_linear_assign_r, pin_b_linear_assign_nxt;
  epa_byte_t   rdata_nxt;
  logic        pin_a_meta_r, pin_a_meta_nxt;
  logic        pin_a_sync_r, pin_a_sync_nxt;
  logic        pin_b_meta_r, pin_b_meta_nxt;
  logic        pin_b_sync_r, pin_b_sync_nxt;
  logic [5:0]  a_req;
  logic [7:0]  b_req;
  logic [3:0]  conv_nxt;
  logic [1:0]  lin_hi_nxt;
  logic [7:0]  lin_lo_nxt;

  // Next values of both registers and the read data
  always_comb begin
    pin_a_converter_assign_nxt = pin_a_converter_assign_r;
    pin_b_linear_assign_nxt    = pin_b_linear_assign_r;
    if (REG_WR && REG_ADDR == `EPA_OFS_PIN_A_CONV) begin
      pin_a_converter_assign_nxt = REG_WDATA & `EPA_A_USED_MASK;
    end
    if (REG_WR && REG_ADDR == `EPA_OFS_PIN_B_LIN) begin
      pin_b_linear_assign_nxt = REG_WDATA;
    end
    case (REG_ADDR)
      `EPA_OFS_PIN_A_CONV: rdata_nxt = pin_a_converter_assign_r & `EPA_A_USED_MASK;
      `EPA_OFS_PIN_B_LIN:  rdata_nxt = pin_b_linear_assign_r;
      default:             rdata_nxt = `EPA_ZERO_BYTE;
    endcase
  end

  // Pin gating for both pins
  epa_gate #(.N(`EPA_A_FIELD_W)) u_gate_a (
    .pin_lvl     (pin_a_sync_r),
    .assign_bits (pin_a_converter_assign_r[`EPA_A_CONV4_BIT:`EPA_A_LIN9_BIT]),
    .req         (a_req)
  );
  epa_gate #(.N(`EPA_B_FIELD_W)) u_gate_b (
    .pin_lvl     (pin_b_sync_r),
    .assign_bits (pin_b_linear_assign_r),
    .req         (b_req)
  );

  // Map requests onto regulator outputs
  always_comb begin
    conv_nxt   = a_req[`EPA_A_CONV4_BIT:`EPA_A_CONV1_BIT];
    // linear 10 and 9 from pin A
    lin_hi_nxt = a_req[`EPA_A_LIN10_BIT:`EPA_A_LIN9_BIT];
    lin_lo_nxt = b_req;
  end

  // Pin synchronisers: two flops per pin before any logic reads the level
  always_comb begin
    pin_a_meta_nxt = ENABLE_PIN_A;
    pin_a_sync_nxt = pin_a_meta_r;
    pin_b_meta_nxt = ENABLE_PIN_B;
    pin_b_sync_nxt = pin_b_meta_r;
  end

  // Synchroniser flops; cleared in reset so no stale pin level outlives it
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      pin_a_meta_r <= `EPA_PIN_IDLE;
      pin_a_sync_r <= `EPA_PIN_IDLE;
      pin_b_meta_r <= `EPA_PIN_IDLE;
      pin_b_sync_r <= `EPA_PIN_IDLE;
    end else begin
      pin_a_meta_r <= pin_a_meta_nxt;
      pin_a_sync_r <= pin_a_sync_nxt;
      pin_b_meta_r <= pin_b_meta_nxt;
      pin_b_sync_r <= pin_b_sync_nxt;
    end
  end

  // Register bank and read data; sync reset reloads the programmed defaults
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      pin_a_converter_assign_r <= OTP_A & `EPA_A_USED_MASK;
      pin_b_linear_assign_r    <= OTP_B;
      REG_RDATA                <= `EPA_ZERO_BYTE;
    end else begin
      pin_a_converter_assign_r <= pin_a_converter_assign_nxt;
      pin_b_linear_assign_r    <= pin_b_linear_assign_nxt;
      REG_RDATA                <= rdata_nxt;
    end
  end

  // Pin request outputs; one stage so every output leaves a flop
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      CONV_PIN_REQ   <= `EPA_CONV_REQ_OFF;
      LIN_HI_PIN_REQ <= `EPA_LIN_HI_REQ_OFF;
      LIN_LO_PIN_REQ <= `EPA_LIN_LO_REQ_OFF;
    end else begin
      CONV_PIN_REQ   <= conv_nxt;
      LIN_HI_PIN_REQ <= lin_hi_nxt;
      LIN_LO_PIN_REQ <= lin_lo_nxt;
    end
  end

  // Checks on the register bank and the pin paths. The four per-output gating checks and
  // the two register read value checks skip the edge after reset: outputs are cleared there
  // while the sampled state may not be, since reset may last a single edge.
  // Reserved bits never read back
  a_reserved_bits_zero: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    $past(REG_ADDR) == `EPA_OFS_PIN_A_CONV |->
      REG_RDATA[`EPA_A_RESERVED_BITS_HI_BIT:`EPA_A_RESERVED_BITS_LO_BIT] == `EPA_RESERVED_BITS_ZERO)
    else $error("Reserved bits read nonzero");

  // Converter 4 follows pin A only when assigned
  a_conv4_gate: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    $past(RSTN) |-> CONV_PIN_REQ[`EPA_OUT_CONV4] ==
      $past(pin_a_sync_r & pin_a_converter_assign_r[`EPA_A_CONV4_BIT]))
    else $error("Converter 4 request wrong");

  // Converters 3..1 follow pin A when assigned
  a_conv_low: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    $past(RSTN) |-> CONV_PIN_REQ[`EPA_OUT_CONV3:`EPA_OUT_CONV1] ==
      $past({`EPA_CONV_LO_W{pin_a_sync_r}} &
      pin_a_converter_assign_r[`EPA_A_CONV3_BIT:`EPA_A_CONV1_BIT]))
    else $error("Converter 3..1 request wrong");

  // Linear 10 and 9 follow pin A when assigned
  a_lin_hi: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    $past(RSTN) |-> LIN_HI_PIN_REQ ==
      $past({`EPA_LIN_HI_W{pin_a_sync_r}} &
      pin_a_converter_assign_r[`EPA_A_LIN10_BIT:`EPA_A_LIN9_BIT]))
    else $error("Linear 10/9 request wrong");

  // Linear 8..1 follow pin B when assigned
  a_lin_lo: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    $past(RSTN) |-> LIN_LO_PIN_REQ ==
      $past({`EPA_LIN_LO_W{pin_b_sync_r}} & pin_b_linear_assign_r))
    else $error("Linear 8..1 request wrong");

  // Reset restores the pin B default
  a_reset_dflt: assert property (@(posedge REF_CLK)
    !RSTN |=> pin_b_linear_assign_r == OTP_B)
    else $error("Pin B default not restored");

  // Pin A default comes from OTP value
  a_otp_load: assert property (@(posedge REF_CLK)
    !RSTN |=> pin_a_converter_assign_r == (OTP_A & `EPA_A_USED_MASK))
    else $error("Pin A default not restored");

  // Write then read returns written pin B byte
  a_wr_rd_b: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (REG_WR && REG_ADDR == `EPA_OFS_PIN_B_LIN) ##1
      (!REG_WR && REG_ADDR == `EPA_OFS_PIN_B_LIN) |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("Pin B readback wrong");

  // A write to the pin A register lands with the reserved bits dropped
  a_wr_a_mask: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    REG_WR && REG_ADDR == `EPA_OFS_PIN_A_CONV |=>
      pin_a_converter_assign_r == ($past(REG_WDATA) & `EPA_A_USED_MASK))
    else $error("Pin A write not masked");

  // A write to the pin B register lands whole
  a_wr_b_land: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    REG_WR && REG_ADDR == `EPA_OFS_PIN_B_LIN |=> pin_b_linear_assign_r == $past(REG_WDATA))
    else $error("Pin B write lost");

  // Reserved bits are never held in the pin A register
  a_reserved_bits_held: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    pin_a_converter_assign_r[`EPA_A_RESERVED_BITS_HI_BIT:`EPA_A_RESERVED_BITS_LO_BIT] == `EPA_RESERVED_BITS_ZERO)
    else $error("Reserved bits stored");

  // Read data mirrors the pin B register addressed one edge earlier
  a_rd_b_value: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    $past(RSTN) && $past(REG_ADDR) == `EPA_OFS_PIN_B_LIN |->
      REG_RDATA == $past(pin_b_linear_assign_r))
    else $error("Pin B read data wrong");

  // Read data mirrors the pin A register addressed one edge earlier
  a_rd_a_value: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    $past(RSTN) && $past(REG_ADDR) == `EPA_OFS_PIN_A_CONV |->
      REG_RDATA == $past(pin_a_converter_assign_r))
    else $error("Pin A read data wrong");

  // A low pin A leaves converters and linear 10/9 without a request
  a_pin_a_idle: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !pin_a_sync_r |=> CONV_PIN_REQ == `EPA_CONV_REQ_OFF &&
      LIN_HI_PIN_REQ == `EPA_LIN_HI_REQ_OFF)
    else $error("Pin A idle but request raised");

  // A low pin B leaves linear 8..1 without a request
  a_pin_b_idle: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !pin_b_sync_r |=> LIN_LO_PIN_REQ == `EPA_LIN_LO_REQ_OFF)
    else $error("Pin B idle but request raised");
endmodule

/* rtl/epa_map.svh */
// Register offsets, field positions and widths of the enable pin assignment registers.
// Assumes inclusion by the package and the design modules; definitions only.
`ifndef EPA_MAP_SVH
`define EPA_MAP_SVH
`define EPA_ADDR_W          8
`define EPA_DATA_W          8
`define EPA_OFS_PIN_A_CONV  8'h30
`define EPA_OFS_PIN_B_LIN   8'h31
`define EPA_A_CONV4_BIT     5
`define EPA_A_CONV1_BIT     2
`define EPA_A_LIN10_BIT     1
`define EPA_A_LIN9_BIT      0
`define EPA_A_USED_MASK     8'h3f
`define EPA_ZERO_BYTE       8'h00
`define EPA_OTP_A_DEFAULT   8'h04
`define EPA_OTP_B_DEFAULT   8'h18
`define EPA_A_CONV3_BIT     4
`define EPA_A_RESERVED_BITS_HI_BIT   7
`define EPA_A_RESERVED_BITS_LO_BIT   6
`define EPA_A_FIELD_W       6
`define EPA_B_FIELD_W       8
`define EPA_OUT_CONV4       3
`define EPA_OUT_CONV3       2
`define EPA_OUT_CONV1       0
`define EPA_CONV_LO_W       3
`define EPA_LIN_HI_W        2
`define EPA_LIN_LO_W        8
`define EPA_RESERVED_BITS_ZERO       2'h0
`define EPA_PIN_IDLE        1'h0
`define EPA_CONV_REQ_OFF    4'h0
`define EPA_LIN_HI_REQ_OFF  2'h0
`define EPA_LIN_LO_REQ_OFF  8'h00
`endif

/* rtl/epa_pkg.sv */
// Types shared by the enable pin assignment register bank.
// Assumes epa_map.svh is on the include path.
`include "epa_map.svh"
package epa_pkg;
  typedef logic [`EPA_DATA_W-1:0] epa_byte_t;
  typedef logic [`EPA_ADDR_W-1:0] epa_addr_t;
endpackage

/* rtl/epa_gate.sv */
// Per-regulator pin gating: an assigned pin drives that regulator's pin request.
// Assumes pin level already synchronised to REF_CLK.
`timescale 1ns/10ps
`include "epa_map.svh"
module epa_gate #(
  parameter int N = 8
) (
  input  wire logic         pin_lvl,  // Synchronised pin level
  input  wire logic [N-1:0] assign_bits, // Assignment bits
  output logic      [N-1:0] req      // Pin request per regulator
);
  // One gate per regulator
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      assign req[g] = pin_lvl & assign_bits[g];
    end
  endgenerate
endmodule

/* test/tb_enable_pin_assignment_regs.sv */
// Self-checking bench for the enable pin assignment register bank.
// Assumes epa_pkg and epa_map.svh are compiled first; bench drives on falling edges.
`timescale 1ns/10ps
`include "epa_map.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module tb_enable_pin_assignment_regs;
  import epa_pkg::*;
  logic       REF_CLK      = 1'b0;
  logic       RSTN         = 1'b0;
  epa_addr_t  REG_ADDR     = 8'h00;
  logic       REG_WR       = 1'b0;
  epa_byte_t  REG_WDATA    = 8'h00;
  epa_byte_t  REG_RDATA;
  logic       ENABLE_PIN_A = 1'b0;
  logic       ENABLE_PIN_B = 1'b0;
  logic [3:0] CONV_PIN_REQ;
  logic [1:0] LIN_HI_PIN_REQ;
  logic [7:0] LIN_LO_PIN_REQ;
  int         fail_count   = 0;
  int         total_checks = 0;
  // 40 MHz clock
  always #12.5 REF_CLK = ~REF_CLK;
  epa_regs dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .ENABLE_PIN_A(ENABLE_PIN_A),
    .ENABLE_PIN_B(ENABLE_PIN_B), .CONV_PIN_REQ(CONV_PIN_REQ),
    .LIN_HI_PIN_REQ(LIN_HI_PIN_REQ), .LIN_LO_PIN_REQ(LIN_LO_PIN_REQ));
  // One-cycle write strobe, then a quiet cycle so strobes never merge
  task automatic wr(input epa_addr_t a, input epa_byte_t d);
    REG_ADDR = a; REG_WDATA = d; REG_WR = 1'b1;
    @(negedge REF_CLK); REG_WR = 1'b0;
    @(negedge REF_CLK);
  endtask
  // Read answers one edge after the address is sampled
  task automatic rd(input epa_addr_t a, input epa_byte_t e, input string nm);
    REG_ADDR = a;
    @(negedge REF_CLK);
    `CHK(nm, e, REG_RDATA)
  endtask
  // Let pin sync and output registers settle
  task automatic settle();
    repeat (4) @(negedge REF_CLK);
  endtask
  task automatic t_defaults();
    rd(8'h30, `EPA_OTP_A_DEFAULT & 8'h3f, "pa dflt");
    rd(8'h31, `EPA_OTP_B_DEFAULT, "pb dflt");
  endtask
  task automatic t_pin_a();
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h3f, "pa reserved_bits");
    ENABLE_PIN_A = 1'b1; settle();
    `CHK("conv all", 4'hf, CONV_PIN_REQ)
    `CHK("lhi all", 2'h3, LIN_HI_PIN_REQ)
    wr(8'h30, 8'h2a); settle();
    `CHK("conv 2a", 4'ha, CONV_PIN_REQ)
    `CHK("lhi 2a", 2'h2, LIN_HI_PIN_REQ)
    wr(8'h30, 8'h15); settle();
    `CHK("conv 15", 4'h5, CONV_PIN_REQ)
    `CHK("lhi 15", 2'h1, LIN_HI_PIN_REQ)
    `CHK("llo pin b off", 8'h00, LIN_LO_PIN_REQ)
    ENABLE_PIN_A = 1'b0; settle();
    `CHK("conv pin off", 4'h0, CONV_PIN_REQ)
  endtask
  task automatic t_pin_b();
    wr(8'h31, 8'ha5);
    rd(8'h31, 8'ha5, "pb rw");
    ENABLE_PIN_B = 1'b1; settle();
    `CHK("llo a5", 8'ha5, LIN_LO_PIN_REQ)
    wr(8'h31, 8'h5a); settle();
    `CHK("llo 5a", 8'h5a, LIN_LO_PIN_REQ)
    `CHK("lhi pin a off", 2'h0, LIN_HI_PIN_REQ)
    ENABLE_PIN_B = 1'b0; settle();
    `CHK("llo pin b low", 8'h00, LIN_LO_PIN_REQ)
    ENABLE_PIN_B = 1'b1;
  endtask
  task automatic t_unmapped();
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00, "unmapped");
    rd(8'h30, 8'h15, "pa kept");
  endtask
  task automatic t_reset();
    RSTN = 1'b0; repeat (2) @(negedge REF_CLK); RSTN = 1'b1;
    rd(8'h31, `EPA_OTP_B_DEFAULT, "pb por");
    rd(8'h30, `EPA_OTP_A_DEFAULT & 8'h3f, "pa por");
    settle();
    `CHK("llo por", `EPA_OTP_B_DEFAULT, LIN_LO_PIN_REQ)
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence after five cycles of reset
  initial begin
    repeat (5) @(negedge REF_CLK);
    RSTN = 1'b1;
    t_defaults(); t_pin_a(); t_pin_b(); t_unmapped(); t_reset();
    close_out();
  end
  // Watchdog at 2000 cycles, far beyond the 59 or so cycles the tests need
  initial begin
    #50000;
    fail_count++;
    close_out();
  end
endmodule
